/* clock_gating_defs.svh */
// Constants for the differential clock output gating block
`ifndef CLOCK_GATING_DEFS_SVH
`define CLOCK_GATING_DEFS_SVH

`define OUTPUT_COUNT          2
`define ENABLE_BYTE_INDEX     8'h02
`define ENABLE_BYTE_RESET     8'hc0
`define FIRST_GATE_BIT_POS    7
`define SECOND_GATE_BIT_POS   6
`define START_ARM_CYCLES      2'h2
`define SYNC_STAGES           2

`endif

/* clock_gating_pkg.sv */
// Types shared by the differential clock output gating block
package clock_gating_pkg;

	typedef struct packed {
		logic p;
		logic n;
	} differential_clock_output_pair_type;

	typedef struct packed {
		logic       write;
		logic [7:0] index;
		logic [7:0] data;
	} config_write_type;

	typedef enum logic [1:0] {
		GATE_STOPPED,
		GATE_ARMING,
		GATE_RUNNING
	} gate_state_type;

endpackage : clock_gating_pkg

/* gate_pin_sync.sv */
// Two-flop synchroniser for the gate pins
`timescale 1ns/1ps
`include "clock_gating_defs.svh"

module gate_pin_sync (
	// Clock and reset
	input  wire logic                        clk_in,
	input  wire logic                        reset_n_in,
	input  wire logic                        clock_enable_in,
	// Pins
	input  wire logic [`OUTPUT_COUNT-1:0]    pin_in,
	output logic      [`OUTPUT_COUNT-1:0]    pin_sync_out
);
	logic [`OUTPUT_COUNT-1:0] first_stage;
	logic [`OUTPUT_COUNT-1:0] next_first_stage;
	logic [`OUTPUT_COUNT-1:0] next_pin_sync;

	always_comb begin
		next_first_stage = first_stage;
		next_pin_sync    = pin_sync_out;
		if (!reset_n_in) begin
			next_first_stage = '0;
			next_pin_sync    = '0;
		end else if (clock_enable_in) begin
			next_first_stage = pin_in;
			next_pin_sync    = first_stage;
		end
	end

	always_ff @(posedge clk_in) begin
		first_stage  <= next_first_stage;
		pin_sync_out <= next_pin_sync;
	end
endmodule : gate_pin_sync

/* differential_clock_output_clock_output_gating.sv */
// Differential clock fanout with per-output glitch-free gating
`timescale 1ns/1ps
`include "clock_gating_defs.svh"

module differential_clock_output_clock_output_gating (
	// Clock and reset
	input  wire logic                                          clk_in,
	input  wire logic                                          reset_n_in,
	input  wire logic                                          clock_enable_in,
	// Gate pins from the system controller
	input  wire logic [`OUTPUT_COUNT-1:0]                      gate_pin_in,
	// Serial configuration access
	input  wire logic                                          program_mode_in,
	input  wire clock_gating_pkg::config_write_type            config_write_in,
	input  wire logic [7:0]                                    config_read_index_in,
	output logic      [7:0]                                    config_read_data_out,
	output logic                                               write_refused_out,
	// Clock outputs and status
	output clock_gating_pkg::differential_clock_output_pair_type [`OUTPUT_COUNT-1:0] differential_clock_output_out,
	output logic      [`OUTPUT_COUNT-1:0]                      output_running_out
);
	import clock_gating_pkg::*;

	// Maps an output number to its enable bit in the configuration byte
	function automatic logic enable_bit(input logic [7:0] cfg, input int unsigned idx);
		enable_bit = (idx == 0) ? cfg[`FIRST_GATE_BIT_POS] : cfg[`SECOND_GATE_BIT_POS];
	endfunction : enable_bit

	// Level of a stopped output: true leg low, complement leg high
	function automatic differential_clock_output_pair_type parked_pair();
		parked_pair = '{p: 1'b0, n: 1'b1};
	endfunction : parked_pair

	// Pair driven while an output follows the reference phase
	function automatic differential_clock_output_pair_type phase_pair(input logic phase);
		phase_pair = '{p: phase, n: ~phase};
	endfunction : phase_pair

	// Selects the configuration byte that holds the enable bits
	function automatic logic is_enable_index(input logic [7:0] index);
		is_enable_index = (index == `ENABLE_BYTE_INDEX);
	endfunction : is_enable_index

	// Gate pins after the two-flop synchroniser
	logic [`OUTPUT_COUNT-1:0] gate_pin_sync;

	gate_pin_sync pin_sync (
		.clk_in          (clk_in),
		.reset_n_in      (reset_n_in),
		.clock_enable_in (clock_enable_in),
		.pin_in          (gate_pin_in),
		.pin_sync_out    (gate_pin_sync)
	);

	// Configuration byte holding the two enable bits
	logic [7:0] enable_byte;
	logic [7:0] next_enable_byte;
	logic [7:0] next_config_read_data;
	logic       next_write_refused;

	always_comb begin
		next_enable_byte      = enable_byte;
		next_config_read_data = config_read_data_out;
		next_write_refused    = write_refused_out;
		if (!reset_n_in) begin
			next_enable_byte      = `ENABLE_BYTE_RESET;
			next_config_read_data = 8'h00;
			next_write_refused    = 1'b0;
		end else if (clock_enable_in) begin
			next_write_refused = 1'b0;
			// Enable byte writes outside program mode are dropped and flagged for one cycle
			if (config_write_in.write && is_enable_index(config_write_in.index)) begin
				if (program_mode_in) begin
					next_enable_byte = config_write_in.data;
				end else begin
					next_write_refused = 1'b1;
				end
			end
			if (is_enable_index(config_read_index_in)) begin
				next_config_read_data = enable_byte;
			end else begin
				next_config_read_data = 8'h00;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		enable_byte          <= next_enable_byte;
		config_read_data_out <= next_config_read_data;
		write_refused_out    <= next_write_refused;
	end

	// Buffered reference clock phase, one output period per two clock cycles
	logic ref_phase;
	logic next_ref_phase;

	always_comb begin
		next_ref_phase = ref_phase;
		if (!reset_n_in) begin
			next_ref_phase = 1'b0;
		end else if (clock_enable_in) begin
			next_ref_phase = ~ref_phase;
		end
	end

	always_ff @(posedge clk_in) begin
		ref_phase <= next_ref_phase;
	end

	// A start is placed where the reference enters its high phase and a stop where it enters its low phase,
	// so no output ever shows a shortened or stretched pulse
	logic start_point;
	logic stop_point;

	always_comb begin
		start_point = next_ref_phase;
		stop_point  = !next_ref_phase;
	end

	// Per-output gating state machines
	gate_state_type                state [`OUTPUT_COUNT];
	gate_state_type                next_state [`OUTPUT_COUNT];
	logic [1:0]                    arm_count [`OUTPUT_COUNT];
	logic [1:0]                    next_arm_count [`OUTPUT_COUNT];
	differential_clock_output_pair_type [`OUTPUT_COUNT-1:0] next_pair;
	logic [`OUTPUT_COUNT-1:0]      next_running;
	logic [`OUTPUT_COUNT-1:0]      request;

	// Run request per output: synchronised pin and enable bit both high
	always_comb begin
		for (int i = 0; i < `OUTPUT_COUNT; i++) begin
			request[i] = gate_pin_sync[i] & enable_bit(enable_byte, i);
		end
	end

	// Per-output start and stop sequencing
	always_comb begin
		for (int i = 0; i < `OUTPUT_COUNT; i++) begin
			next_state[i]     = state[i];
			next_arm_count[i] = arm_count[i];
			if (!reset_n_in) begin
				next_state[i]     = GATE_STOPPED;
				next_arm_count[i] = 2'h0;
			end else if (clock_enable_in) begin
				unique case (state[i])
					GATE_STOPPED: begin
						next_arm_count[i] = 2'h0;
						if (request[i]) begin
							next_state[i] = GATE_ARMING;
						end
					end
					GATE_ARMING: begin
						// Dropping the request here aborts the start with the output still parked
						if (!request[i]) begin
							next_state[i] = GATE_STOPPED;
						end else if (start_point) begin
							// Counts rising edges, then starts on a full high phase
							if (arm_count[i] == `START_ARM_CYCLES) begin
								next_state[i] = GATE_RUNNING;
							end else begin
								next_arm_count[i] = arm_count[i] + 2'h1;
							end
						end
					end
					GATE_RUNNING: begin
						// Stops only when the next phase is low, so the period completes
						if (!request[i] && stop_point) begin
							next_state[i] = GATE_STOPPED;
						end
					end
					// An unused state code falls back to stopped
					default: begin
						next_state[i] = GATE_STOPPED;
					end
				endcase
			end
		end
	end

	// Both legs are registered together so they switch on the same edge
	always_comb begin
		for (int i = 0; i < `OUTPUT_COUNT; i++) begin
			next_pair[i]    = differential_clock_output_out[i];
			next_running[i] = output_running_out[i];
			if (!reset_n_in) begin
				next_pair[i]    = parked_pair();
				next_running[i] = 1'b0;
			end else if (clock_enable_in) begin
				next_running[i] = (next_state[i] == GATE_RUNNING);
				if (next_state[i] == GATE_RUNNING) begin
					next_pair[i] = phase_pair(next_ref_phase);
				end else begin
					next_pair[i] = parked_pair();
				end
			end
		end
	end

	always_ff @(posedge clk_in) begin
		for (int i = 0; i < `OUTPUT_COUNT; i++) begin
			state[i]     <= next_state[i];
			arm_count[i] <= next_arm_count[i];
		end
		differential_clock_output_out <= next_pair;
		output_running_out            <= next_running;
	end
endmodule : differential_clock_output_clock_output_gating

/* differential_clock_output_clock_output_gating_sva.sv */
// Assertion checker for the differential clock output gating block
`timescale 1ns/1ps
`include "clock_gating_defs.svh"

module differential_clock_output_clock_output_gating_sva (
	// Clock, reset and inputs
	input wire logic	clk_in,
	input wire logic	reset_n_in,
	input wire logic	clock_enable_in,
	input wire logic [`OUTPUT_COUNT-1:0]	gate_pin_in,
	input wire logic	program_mode_in,
	input wire clock_gating_pkg::config_write_type	config_write_in,
	input wire logic [7:0]	config_read_index_in,
	// Outputs
	input wire logic [7:0]	config_read_data_out,
	input wire logic	write_refused_out,
	input wire clock_gating_pkg::differential_clock_output_pair_type [`OUTPUT_COUNT-1:0]	differential_clock_output_out,
	input wire logic [`OUTPUT_COUNT-1:0]	output_running_out
);
	import clock_gating_pkg::*;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!reset_n_in);
	logic [1:0]	p;
	logic [1:0]	n;
	logic	wr2;
	logic	rd2;
	logic	bad;
	assign p = {differential_clock_output_out[1].p, differential_clock_output_out[0].p};
	assign n = {differential_clock_output_out[1].n, differential_clock_output_out[0].n};
	assign wr2 = clock_enable_in && config_write_in.write && config_write_in.index == 8'h02;
	assign rd2 = clock_enable_in && config_read_index_in == 8'h02;
	assign bad = wr2 && !program_mode_in;

	a_pair_complement: assert property (n == ~p) else $error("pair not complementary");
	a_stop_parks_low: assert property ((~output_running_out & p) == 2'h0) else $error("stopped output high");
	a_run_toggles: assert property (output_running_out[0] && $past(output_running_out[0])
		&& $past(clock_enable_in) |-> p[0] != $past(p[0])) else $error("running output missed a toggle");
	a_refuse_pulse: assert property (bad |=> write_refused_out) else $error("refusal missing");
	a_refuse_cause: assert property (write_refused_out |-> $past(bad)) else $error("refusal without cause");
	a_write_stored: assert property (wr2 && program_mode_in ##1 rd2
		|=> config_read_data_out == $past(config_write_in.data, 2)) else $error("written byte not read back");
	a_read_other: assert property (clock_enable_in && config_read_index_in != 8'h02
		|=> config_read_data_out == 8'h00) else $error("other index not zero");
	a_start_bound: assert property ($rose(gate_pin_in[0]) && rd2 && config_read_data_out[7]
		|-> ##[1:12] (output_running_out[0] || !gate_pin_in[0] || !clock_enable_in)) else $error("start too late");
	a_pin_low_stops: assert property ((!gate_pin_in[1] && clock_enable_in)[*8]
		|-> !output_running_out[1]) else $error("runs with pin low");
	a_bit_low_stops: assert property ((rd2 && !config_read_data_out[6])[*8]
		|-> !output_running_out[1]) else $error("runs with bit low");
endmodule : differential_clock_output_clock_output_gating_sva

bind differential_clock_output_clock_output_gating differential_clock_output_clock_output_gating_sva sva (.clk_in, .reset_n_in, .clock_enable_in, .gate_pin_in,
	.program_mode_in, .config_write_in, .config_read_index_in, .config_read_data_out, .write_refused_out,
	.differential_clock_output_out, .output_running_out);

/* gate_controller_model.sv */
// System controller model that drives the gate pins
`timescale 1ns/1ps

module gate_controller_model (
	// Clock and requests
	input wire logic	clk_in,
	input wire logic [1:0]	gate_request_in,
	// Gate pins, always driven
	output logic [1:0]	gate_pin_out = 2'h0
);
	always @(posedge clk_in) begin
		gate_pin_out <= #1 gate_request_in;
	end
endmodule : gate_controller_model

/* differential_clock_output_clock_output_gating_tb.sv */
// Self-checking testbench for the differential clock output gating block
`timescale 1ns/1ps

module differential_clock_output_clock_output_gating_tb;
	import clock_gating_pkg::*;
	logic	clk_in = 0;
	logic	reset_n_in = 0;
	logic	enable = 1;
	logic	pmode = 0;
	logic [1:0]	req = 0;
	logic [1:0]	pins;
	logic [1:0]	run;
	logic [7:0]	rd_index = 8'h02;
	logic [7:0]	rd_data;
	logic	refused;
	config_write_type	cfg = '0;
	differential_clock_output_pair_type [1:0]	dco;
	int	errors = 0;
	int	n_checks = 0;

	gate_controller_model ctrl (.clk_in(clk_in), .gate_request_in(req), .gate_pin_out(pins));
	differential_clock_output_clock_output_gating uut (.clk_in(clk_in), .reset_n_in(reset_n_in), .clock_enable_in(enable),
		.gate_pin_in(pins), .program_mode_in(pmode), .config_write_in(cfg), .config_read_index_in(rd_index),
		.config_read_data_out(rd_data), .write_refused_out(refused), .differential_clock_output_out(dco),
		.output_running_out(run));

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH %0t got %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic tick(input int k);
		repeat (k) @(posedge clk_in);
		#1;
	endtask : tick
	task automatic wait_run(input logic [1:0] exp);
		for (int i = 0; i < 14 && run !== exp; i++) tick(1);
		chk(run, exp);
	endtask : wait_run
	task automatic write_byte(input logic [7:0] data, input logic mode);
		pmode = mode;
		cfg = '{1'b1, 8'h02, data};
		tick(1);
		cfg.write = 1'b0;
	endtask : write_byte
	task automatic t_defaults;
		reset_n_in = 0;
		tick(3);
		reset_n_in = 1;
		tick(2);
		chk(rd_data, 8'hc0);
		chk(dco, 8'h05);
		rd_index = 8'h00;
		tick(2);
		chk(rd_data, 8'h00);
		rd_index = 8'h02;
		tick(2);
	endtask : t_defaults
	task automatic t_gating;
		differential_clock_output_pair_type [1:0] d;
		req = 2'b11;
		wait_run(2'b11);
		req = 2'b10;
		wait_run(2'b10);
		chk(dco[0], 8'h01);
		d = dco;
		enable = 0;
		tick(3);
		chk(dco, d);
		enable = 1;
		tick(1);
		chk(dco[1].p, !d[1].p);
	endtask : t_gating
	task automatic t_config;
		write_byte(8'h00, 0);
		chk(refused, 1'b1);
		tick(1);
		chk(rd_data, 8'hc0);
		req = 2'b11;
		wait_run(2'b11);
		write_byte(8'h45, 1);
		tick(1);
		chk(rd_data, 8'h45);
		wait_run(2'b10);
		write_byte(8'hc0, 1);
		wait_run(2'b11);
		req = 2'b01;
		wait_run(2'b01);
		tick(8);
		chk(dco[1], 8'h01);
		req = 2'b11;
		wait_run(2'b11);
		write_byte(8'h80, 1);
		wait_run(2'b01);
		tick(8);
		chk(rd_data, 8'h80);
		req = 2'b00;
		wait_run(2'b00);
		tick(4);
		chk(dco, 8'h05);
		write_byte(8'h00, 1);
	endtask : t_config
	task automatic end_of_test;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : end_of_test

	initial begin
		forever #2.5 clk_in = ~clk_in;
	end
	initial begin
		#5000;
		errors++;
		end_of_test();
	end
	initial begin
		t_defaults();
		t_gating();
		t_config();
		t_defaults();
		end_of_test();
	end
endmodule : differential_clock_output_clock_output_gating_tb
